// >>> common/lcp_pkg.sv
/*
 * Constants and carriers for the link control / power management
 * capability register slice of one switch port.
 * Assumes a 32-bit APB slave with a 12-bit byte address.
 */
package lcp_pkg;

   // ------------------------------------------------------------------
   // Bus geometry
   // ------------------------------------------------------------------
   localparam int unsigned ADDR_W          = 12;
   localparam int unsigned DATA_W          = 32;

   // ------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------------
   localparam logic [7:0]  IDX_DEV_CAP2    = 8'h64;
   localparam logic [7:0]  IDX_DEV_CTL2    = 8'h68;
   localparam logic [7:0]  IDX_DEV_STS2    = 8'h6a;
   localparam logic [7:0]  IDX_LINK_CAP2   = 8'h6c;
   localparam logic [7:0]  IDX_LINK_CTL2   = 8'h70;
   localparam logic [7:0]  IDX_LINK_STS2   = 8'h72;
   localparam logic [7:0]  IDX_SLOT_CAP2   = 8'h74;
   localparam logic [7:0]  IDX_SLOT_CTL2   = 8'h78;
   localparam logic [7:0]  IDX_SLOT_STS2   = 8'h7a;
   localparam logic [7:0]  IDX_PM_CAP_HDR  = 8'hc0;

   // ------------------------------------------------------------------
   // Link control two fields
   // ------------------------------------------------------------------
   localparam int unsigned TLS_LSB         = 0;
   localparam int unsigned TLS_W           = 4;
   localparam int unsigned ENTER_COMPLIANCE_CTL_BIT       = 4;
   localparam int unsigned HW_AUTONOMOUS_SPEED_DISABLE_BIT        = 5;
   localparam logic [3:0]  TLS_RST         = 4'h0;
   localparam logic        ENTER_COMPLIANCE_CTL_RST       = 1'b0;
   localparam logic        HW_AUTONOMOUS_SPEED_DISABLE_RST        = 1'b0;

   // Speed encodings
   localparam logic [3:0]  SPEED_GEN1      = 4'h1;
   localparam logic [3:0]  SPEED_GEN2      = 4'h2;
   localparam logic [3:0]  DEV_MAX_SPEED   = SPEED_GEN1;

   // ------------------------------------------------------------------
   // Power management capability header fields
   // ------------------------------------------------------------------
   localparam int unsigned CAPABILITY_IDENTIFIER_LSB       = 0;
   localparam int unsigned NEXT_CAPABILITY_POINTER_LSB      = 8;
   localparam int unsigned VER_LSB         = 16;
   localparam int unsigned PM_EVENT_CLOCK_FLAG_BIT      = 19;
   localparam logic [7:0]  CAPABILITY_IDENTIFIER_VAL       = 8'h01;
   localparam logic [7:0]  NEXT_CAPABILITY_POINTER_UP_RST   = 8'h00;
   localparam logic [7:0]  NEXT_CAPABILITY_POINTER_DN_RST   = 8'hd0;
   localparam logic [2:0]  VER_VAL         = 3'h3;
   localparam logic        PM_EVENT_CLOCK_FLAG_VAL      = 1'b0;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic       hw_autonomous_speed_disable;
      logic       enter_compliance_ctl;
      logic [3:0] target_link_speed;
   } lcp_lctl_t;

   typedef struct packed {
      logic       req;
      logic       reliability;
      logic [3:0] target;
   } lcp_spd_req_t;

endpackage : lcp_pkg

// >>> src/lcp_sync.sv
/*
 * Two-flop level synchroniser, one bit per lane.
 * Assumes inputs are quasi-static levels from outside the pclk domain.
 */
module lcp_sync
   import lcp_pkg::*;
#(
   parameter int unsigned WIDTH = 1
)
(
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   // ------------------------------------------------------------------
   // Two stages; the first is read by the second only
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_q   <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule : lcp_sync

// >>> src/lcp_regs.sv
/*
 * APB register slice: second-generation device/link/slot registers,
 * link control two, and the power management capability header.
 * Assumes port type and legacy mode are pin levels, and that hot reset
 * and the unlock level come from logic on pclk.
 */
// The APB register port was left to the implementer.

module lcp_regs
   import lcp_pkg::*;
(
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [ADDR_W-1:0]  paddr,
   input  wire logic [DATA_W-1:0]  pwdata,
   input  wire logic [3:0]         pstrb,
   output logic      [DATA_W-1:0]  prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Port configuration pins
   input  wire logic               port_downstream_pin,
   input  wire logic               legacy_mode_pin,
   // Control from port logic
   input  wire logic               cfg_unlock,
   input  wire logic               hot_reset,
   // Link training interface
   output lcp_lctl_t               link_ctl,
   output logic      [3:0]         adv_max_speed,
   output logic      [3:0]         compliance_speed,
   output logic                    compliance_start,
   // Speed change arbitration
   input  wire logic [3:0]         cur_speed,
   input  wire lcp_spd_req_t       spd_req,
   output logic                    spd_grant
);

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   logic              downstream;
   logic              legacy;
   logic [3:0]        tls_q;
   logic              enter_compliance_ctl_q;
   logic              hw_autonomous_speed_disable_q;
   logic [7:0]        next_capability_pointer_q;
   logic              next_capability_pointer_ovr_q;
   logic              hot_reset_q;
   logic              hot_rise;
   logic [DATA_W-1:0] prdata_q;
   logic              pslverr_q;
   logic              setup;
   logic              wr_acc;
   logic              addr_ok;
   logic [7:0]        idx;
   logic              hit;
   logic [DATA_W-1:0] rd_mux;
   lcp_lctl_t         lctl_eff;
   logic [7:0]        next_capability_pointer_eff;
   logic [3:0]        adv_d;
   logic              wr_lctl;
   logic              wr_power_mgmt_capability_header;

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   lcp_sync #(
      .WIDTH    (2)
   ) u_pin_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({port_downstream_pin, legacy_mode_pin}),
      .sync_out ({downstream, legacy})
   );

   // ------------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------------
   assign setup    = psel & ~penable;
   assign wr_acc   = psel & penable & pwrite & pready;
   assign addr_ok  = (paddr[1:0] == 2'h0) & (paddr[ADDR_W-1:10] == 2'h0);
   assign idx      = paddr[9:2];
   assign wr_lctl  = wr_acc & ~pslverr_q & (idx == IDX_LINK_CTL2);
   assign wr_power_mgmt_capability_header = wr_acc & ~pslverr_q & (idx == IDX_PM_CAP_HDR);
   assign pready   = 1'b1;
   assign prdata   = prdata_q;
   assign pslverr  = pslverr_q;

   always_comb
   begin
      case (idx)
         IDX_DEV_CAP2, IDX_DEV_CTL2, IDX_DEV_STS2,
         IDX_LINK_CAP2, IDX_LINK_CTL2, IDX_LINK_STS2,
         IDX_SLOT_CAP2, IDX_SLOT_CTL2, IDX_SLOT_STS2,
         IDX_PM_CAP_HDR:
            hit = addr_ok;
         default:
            hit = 1'b0;
      endcase
   end

   // ------------------------------------------------------------------
   // Effective field values
   // ------------------------------------------------------------------
   always_comb
   begin
      if (legacy)
      begin
         lctl_eff = '0;
      end
      else
      begin
         lctl_eff.target_link_speed   = tls_q;
         lctl_eff.enter_compliance_ctl = enter_compliance_ctl_q;
         lctl_eff.hw_autonomous_speed_disable  = hw_autonomous_speed_disable_q;
      end
   end

   // Default follows the port type until software overrides it
   always_comb
   begin
      if (next_capability_pointer_ovr_q)
         next_capability_pointer_eff = next_capability_pointer_q;
      else if (downstream)
         next_capability_pointer_eff = NEXT_CAPABILITY_POINTER_DN_RST;
      else
         next_capability_pointer_eff = NEXT_CAPABILITY_POINTER_UP_RST;
   end

   // ------------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------------
   // Everything not listed below reads as zero
   always_comb
   begin
      rd_mux = '0;
      if (idx == IDX_LINK_CTL2)
      begin
         rd_mux[TLS_LSB +: TLS_W] = lctl_eff.target_link_speed;
         rd_mux[ENTER_COMPLIANCE_CTL_BIT]        = lctl_eff.enter_compliance_ctl;
         rd_mux[HW_AUTONOMOUS_SPEED_DISABLE_BIT]         = lctl_eff.hw_autonomous_speed_disable;
      end
      else if (idx == IDX_PM_CAP_HDR)
      begin
         rd_mux[CAPABILITY_IDENTIFIER_LSB +: 8]   = CAPABILITY_IDENTIFIER_VAL;
         rd_mux[NEXT_CAPABILITY_POINTER_LSB +: 8]  = next_capability_pointer_eff;
         rd_mux[VER_LSB +: 3]     = VER_VAL;
         rd_mux[PM_EVENT_CLOCK_FLAG_BIT]       = PM_EVENT_CLOCK_FLAG_VAL;
      end
   end

   // ------------------------------------------------------------------
   // Read data and error, captured in the setup cycle
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q  <= '0;
         pslverr_q <= 1'b0;
      end
      else if (setup)
      begin
         pslverr_q <= ~hit;
         if (hit & ~pwrite)
            prdata_q <= rd_mux;
         else
            prdata_q <= '0;
      end
   end

   // ------------------------------------------------------------------
   // Link control two storage
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tls_q  <= TLS_RST;
         hw_autonomous_speed_disable_q <= HW_AUTONOMOUS_SPEED_DISABLE_RST;
      end
      // Hot reset restores the non-sticky fields every cycle it is high
      else if (hot_reset)
      begin
         tls_q  <= TLS_RST;
         hw_autonomous_speed_disable_q <= HW_AUTONOMOUS_SPEED_DISABLE_RST;
      end
      else if (wr_lctl & pstrb[0] & ~legacy)
      begin
         tls_q  <= pwdata[TLS_LSB +: TLS_W];
         hw_autonomous_speed_disable_q <= pwdata[HW_AUTONOMOUS_SPEED_DISABLE_BIT];
      end
   end

   // Sticky: of the two resets, only the bus reset clears it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         enter_compliance_ctl_q <= ENTER_COMPLIANCE_CTL_RST;
      else if (wr_lctl & pstrb[0] & ~legacy & ~hot_reset)
         enter_compliance_ctl_q <= pwdata[ENTER_COMPLIANCE_CTL_BIT];
   end

   // ------------------------------------------------------------------
   // Next pointer, writable while unlocked
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         next_capability_pointer_q     <= NEXT_CAPABILITY_POINTER_UP_RST;
         next_capability_pointer_ovr_q <= 1'b0;
      end
      else if (wr_power_mgmt_capability_header & pstrb[1] & cfg_unlock)
      begin
         next_capability_pointer_q     <= pwdata[NEXT_CAPABILITY_POINTER_LSB +: 8];
         next_capability_pointer_ovr_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Training speed limit and compliance speed
   // ------------------------------------------------------------------
   // The device runs at 2.5G only, so the cap never rises above it
   always_comb
   begin
      adv_d = DEV_MAX_SPEED;
      if (downstream &&
          (lctl_eff.target_link_speed == SPEED_GEN1 || lctl_eff.target_link_speed == SPEED_GEN2) &&
          lctl_eff.target_link_speed < DEV_MAX_SPEED)
         adv_d = lctl_eff.target_link_speed;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         adv_max_speed    <= DEV_MAX_SPEED;
         compliance_speed <= TLS_RST;
         link_ctl         <= '0;
      end
      else
      begin
         adv_max_speed    <= adv_d;
         compliance_speed <= lctl_eff.target_link_speed;
         link_ctl         <= lctl_eff;
      end
   end

   // ------------------------------------------------------------------
   // Compliance entry on hot reset
   // ------------------------------------------------------------------
   // Edge of the hot reset level; the history flop idles low like the input
   assign hot_rise = hot_reset & ~hot_reset_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hot_reset_q      <= 1'b0;
         compliance_start <= 1'b0;
      end
      else
      begin
         hot_reset_q      <= hot_reset;
         compliance_start <= hot_rise & lctl_eff.enter_compliance_ctl;
      end
   end

   // ------------------------------------------------------------------
   // Autonomous speed change gate
   // ------------------------------------------------------------------
   // Locked: only reliability-driven down-shifts get through
   always_comb
   begin
      if (!spd_req.req)
         spd_grant = 1'b0;
      else if (!lctl_eff.hw_autonomous_speed_disable)
         spd_grant = 1'b1;
      else
         spd_grant = spd_req.reliability &
                     (spd_req.target < cur_speed);
   end

endmodule : lcp_regs

// >>> test/lcp_regs_sva.sv
/*
 * Port checker for the link control / pm capability register slice.
 * Assumes it is bound onto lcp_regs and that everything runs on pclk.
 */
module lcp_regs_chk
   import lcp_pkg::*;
(
   // Clock, reset and bus
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [DATA_W-1:0] prdata,
   // Link side
   input  wire logic              legacy_mode_pin,
   input  wire logic              hot_reset,
   input  wire lcp_lctl_t         link_ctl,
   input  wire logic [3:0]        adv_max_speed,
   input  wire logic [3:0]        compliance_speed,
   input  wire logic              compliance_start,
   input  wire lcp_spd_req_t      spd_req,
   input  wire logic              spd_grant
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire rd_acc = psel && penable && !pwrite;

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   property p_adv; adv_max_speed == SPEED_GEN1; endproperty
   a_adv: assert property (p_adv)
      else $error("Speed cap is not the 2.5G code");
   property p_cspd; compliance_speed == link_ctl.target_link_speed; endproperty
   a_cspd: assert property (p_cspd)
      else $error("Compliance speed differs from target speed");
   property p_legacy; legacy_mode_pin [*4] |-> link_ctl == 6'h0; endproperty
   a_legacy: assert property (p_legacy)
      else $error("Link fields not zero in legacy mode");
   property p_cstart;
      $rose(hot_reset) && link_ctl.enter_compliance_ctl |=> compliance_start;
   endproperty
   a_cstart: assert property (p_cstart)
      else $error("No compliance pulse after hot reset");
   property p_cpulse;
      compliance_start |-> ($past(hot_reset) && !$past(hot_reset, 2))
         ##1 !compliance_start;
   endproperty
   a_cpulse: assert property (p_cpulse)
      else $error("Compliance pulse without cause or too long");
   property p_grant;
      spd_req.req && !spd_req.reliability
         |=> link_ctl.hw_autonomous_speed_disable == !$past(spd_grant);
   endproperty
   a_grant: assert property (p_grant)
      else $error("Speed change grant ignores the speed lock");
   property p_pmhdr;
      rd_acc && paddr == 12'h300 |-> prdata[19:0] ==
         {4'h3, prdata[15:8], 8'h01};
   endproperty
   a_pmhdr: assert property (p_pmhdr)
      else $error("Capability header constants wrong");
   property p_rsvd;
      rd_acc && paddr inside {12'h190, 12'h1a0, 12'h1a8, 12'h1b0,
         12'h1c8, 12'h1d0, 12'h1e0, 12'h1e8} |-> prdata == 32'h0;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("Reserved register reads nonzero");
   property p_sticky; hot_reset && link_ctl.enter_compliance_ctl |=> link_ctl.enter_compliance_ctl;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("Compliance bit lost during hot reset");
endmodule : lcp_regs_chk

bind lcp_regs lcp_regs_chk lcp_regs_chk_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .legacy_mode_pin(legacy_mode_pin), .hot_reset(hot_reset),
   .link_ctl(link_ctl), .adv_max_speed(adv_max_speed),
   .compliance_speed(compliance_speed),
   .compliance_start(compliance_start), .spd_req(spd_req),
   .spd_grant(spd_grant));

// >>> test/lcp_regs_test.sv
/*
 * Self-checking bench for lcp_regs against a behavioural model.
 * Assumes an APB slave with pready and a single 125 MHz clock.
 */
module lcp_regs_test
   import lcp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(nm, e, g) \
   begin compares++; if ((e) !== (g)) begin miscompares++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
   logic               pclk = 0, presetn = 0, psel = 0, penable = 0;
   logic               pwrite = 0, pready, pslverr, rerr, cstart, grant;
   logic               dn_pin = 0, leg_pin = 0, unlock = 0, hrst = 0;
   logic [ADDR_W-1:0]  paddr = '0;
   logic [DATA_W-1:0]  pwdata = '0, prdata, rdat;
   logic [3:0]         cur = 4'h1, adv, cspd;
   lcp_lctl_t          lctl;
   lcp_spd_req_t       sreq = '0;
   int                 compares = 0, miscompares = 0, seed = 32'h1c28;
   int                 spd_m = 0, comp_m = 0, lock_m = 0, ptr_m = 0;
   int                 leg_m = 0, i, v;
   logic [11:0]        rsv [8] = '{12'h190, 12'h1a0, 12'h1a8, 12'h1b0,
                                   12'h1c8, 12'h1d0, 12'h1e0, 12'h1e8};
   logic [11:0]        bad [3] = '{12'h004, 12'h1c1, 12'hc00};

   always #4 pclk = ~pclk;

   lcp_regs lcp_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port_downstream_pin(dn_pin), .legacy_mode_pin(leg_pin),
      .cfg_unlock(unlock), .hot_reset(hrst), .link_ctl(lctl),
      .adv_max_speed(adv), .compliance_speed(cspd),
      .compliance_start(cstart), .cur_speed(cur), .spd_req(sreq),
      .spd_grant(grant));

   // ---------------------------------------------------------------
   // Bus and model tasks
   // ---------------------------------------------------------------
   task give_verdict;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict

   function automatic logic [31:0] exp_rd(input logic [11:0] a);
      exp_rd = 32'h0;
      if (a == 12'h1c0 && leg_m == 0)
         exp_rd = {26'h0, 1'(lock_m), 1'(comp_m), 4'(spd_m)};
      if (a == 12'h300)
         exp_rd = {12'h0, 4'h3, 8'(ptr_m), 8'h01};
   endfunction : exp_rd

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
      begin
         miscompares++;
         give_verdict;
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (wr && a == 12'h1c0 && leg_m == 0 && !hrst)
      begin
         spd_m = d[3:0];
         comp_m = d[4];
         lock_m = d[5];
      end
      if (wr && a == 12'h300 && unlock)
         ptr_m = d[15:8];
   endtask : apb

   task automatic rchk(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
      `CHK("read data", exp_rd(a), rdat)
      `CHK("slave error", 1'b0, rerr)
   endtask : rchk

   task automatic pchk;
      logic [31:0] ev;
      #1;
      ev = exp_rd(12'h1c0);
      `CHK("link ctl", ev[5:0], lctl)
      `CHK("cmpl speed", ev[3:0], cspd)
      `CHK("speed cap", 4'h1, adv)
      @(posedge pclk);
   endtask : pchk

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      foreach (rsv[k])
      begin
         rchk(rsv[k]);
         apb(1'b1, rsv[k], $random(seed));
         rchk(rsv[k]);
      end
      rchk(12'h300);
      foreach (bad[k])
      begin
         apb(1'b1, bad[k], 32'hffff_ffff);
         `CHK("bad addr", 1'b1, rerr)
      end
      rchk(12'h1c0);
      for (i = 0; i < 8; i++)
      begin
         v = $random(seed);
         apb(1'b1, 12'h1c0, {v[31:4], SPEED_GEN1});
         rchk(12'h1c0);
         pchk;
      end
      for (i = 0; i < 16; i++)
      begin
         if (i % 8 == 0)
            apb(1'b1, 12'h1c0, (i < 8) ? 32'h21 : 32'h01);
         v = $random(seed);
         sreq <= {1'b1, v[4], v[3:0]};
         cur <= v[7:4];
         #1;
         `CHK("grant", lock_m == 0 || (v[4] && v[3:0] < v[7:4]), grant)
         @(posedge pclk);
      end
      sreq <= '0;
      apb(1'b1, 12'h300, 32'hffff_5aff);
      rchk(12'h300);
      unlock <= 1'b1;
      apb(1'b1, 12'h300, 32'h0000_5a00);
      unlock <= 1'b0;
      rchk(12'h300);
      apb(1'b1, 12'h1c0, 32'h31);
      hrst <= 1'b1;
      @(posedge pclk);
      #1;
      `CHK("cmpl start", 1'b1, cstart)
      @(posedge pclk);
      #1;
      `CHK("cmpl end", 1'b0, cstart)
      @(posedge pclk);
      spd_m = 0;
      lock_m = 0;
      apb(1'b1, 12'h1c0, 32'h1);
      hrst <= 1'b0;
      rchk(12'h1c0);
      leg_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      leg_m = 1;
      pchk;
      apb(1'b1, 12'h1c0, 32'h21);
      rchk(12'h1c0);
      leg_pin <= 1'b0;
      repeat (4) @(posedge pclk);
      leg_m = 0;
      rchk(12'h1c0);
      presetn <= 1'b0;
      dn_pin <= 1'b1;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      comp_m = 0;
      ptr_m = 8'hd0;
      rchk(12'h300);
      rchk(12'h1c0);
      pchk;
      give_verdict;
   end
endmodule : lcp_regs_test
